// ### idw_pkg.sv
// How it works
// - Two bytes fill the 16-bit word, high byte first, MSB first.
// - A complete shifted-in word is copied into the DAC register.
// - Top word bit is an active-high soft power-down control.
// - Word bit 14 has no function and is ignored.
// - DAC code is word bits 13 down to 4.
// - Word bits 3 down to 0 are ignored.
// - Reads return the word high byte first, MSB first.
// - Slave address 0001100, low two address bits ignored.
// - After a completed read the word clears to zero.
// - Address and both write data bytes are acknowledged on the ninth pulse; read bytes are acked by the master.
package idw_pkg;
  // ************************************************
  // Word layout
  // ************************************************
  localparam int WORD_W = 16;
  localparam int PD_POS = 15;
  localparam int CODE_HI = 13;
  localparam int CODE_LO = 4;
  localparam int CODE_W = 10;
  localparam logic [4:0] ADDR_TOP = 5'h03;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [9:0] CODE_RST = 10'h000;
  localparam logic [3:0] BIT_LAST = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_WDAT = 3'b010,
    ST_RDAT = 3'b011,
    ST_SKIP = 3'b100
  } idw_state_t;
endpackage

// ### idw_sync.sv
module idw_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  logic meta_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b1;
      dout <= 1'b1;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

// ### idw_top.sv
module idw_top (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic soft_power_down_bit,
  output logic [9:0] dac_code_bits
);
  // ************************************************
  // Reset release and pin sampling
  // ************************************************
  logic rst_m_q, rst_n_q, scl_s, sda_s;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_m_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_n_q <= rst_m_q;
    end
  end
  idw_sync u_scl (.clk(ref_clk), .rst_n(rst_n_q), .din(scl_i), .dout(scl_s));
  idw_sync u_sda (.clk(ref_clk), .rst_n(rst_n_q), .din(sda_i), .dout(sda_s));

  // ************************************************
  // State
  // ************************************************
  // Local alias keeps the state struct readable
  typedef idw_pkg::idw_state_t idw_state_t;
  typedef struct packed {
    logic scl_p;
    logic sda_p;
    idw_state_t st;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic byten;
    logic ackph;
    logic rd_done;
    logic [15:0] word;
    logic pd;
    logic [9:0] code;
    logic sda_oe;
  } idw_regs_t;
  idw_regs_t s_q, s_d;

  logic rise, fall, start_c, stop_c;
  assign rise = scl_s & ~s_q.scl_p;
  assign fall = ~scl_s & s_q.scl_p;
  assign start_c = scl_s & s_q.scl_p & s_q.sda_p & ~sda_s;
  assign stop_c = scl_s & s_q.scl_p & ~s_q.sda_p & sda_s;

  always_comb begin
    s_d = s_q;
    s_d.scl_p = scl_s;
    s_d.sda_p = sda_s;
    if (start_c || stop_c) begin
      if (s_q.rd_done) begin
        s_d.word = idw_pkg::WORD_RST;
      end
      s_d.rd_done = 1'b0;
      s_d.st = start_c ? idw_pkg::ST_ADDR : idw_pkg::ST_IDLE;
      s_d.bitn = 4'h0;
      s_d.ackph = 1'b0;
      s_d.byten = 1'b0;
      s_d.sda_oe = 1'b0;
    end else if (rise && !s_q.ackph && s_q.st != idw_pkg::ST_IDLE) begin
      s_d.sh = {s_q.sh[6:0], sda_s};
      s_d.bitn = s_q.bitn + 4'h1;
    end else if (fall && s_q.st != idw_pkg::ST_IDLE && s_q.st != idw_pkg::ST_SKIP) begin
      if (s_q.ackph) begin
        s_d.ackph = 1'b0;
        s_d.sda_oe = 1'b0;
        s_d.bitn = 4'h0;
        if (s_q.st == idw_pkg::ST_RDAT) begin
          // Both bytes sent: stay off the line until the next start or stop
          if (s_q.rd_done) begin
            s_d.st = idw_pkg::ST_SKIP;
          end else if (s_q.byten) begin
            s_d.sda_oe = ~s_q.word[7];
          end else begin
            s_d.sda_oe = ~s_q.word[idw_pkg::PD_POS];
          end
        end
      end else if (s_q.bitn == idw_pkg::BIT_LAST) begin
        unique case (s_q.st)
          idw_pkg::ST_ADDR: begin
            if (s_q.sh[7:3] == idw_pkg::ADDR_TOP) begin
              s_d.ackph = 1'b1;
              s_d.sda_oe = 1'b1;
              s_d.st = s_q.sh[0] ? idw_pkg::ST_RDAT : idw_pkg::ST_WDAT;
              s_d.byten = 1'b0;
            end else begin
              s_d.st = idw_pkg::ST_SKIP;
            end
          end
          idw_pkg::ST_WDAT: begin
            s_d.ackph = 1'b1;
            s_d.sda_oe = 1'b1;
            if (!s_q.byten) begin
              s_d.word[15:8] = s_q.sh;
              s_d.byten = 1'b1;
            end else begin
              s_d.word[7:0] = s_q.sh;
              // Only a full word reaches the DAC register
              s_d.pd = s_q.word[idw_pkg::PD_POS];
              s_d.code = {s_q.word[idw_pkg::CODE_HI:8], s_q.sh[7:4]};
              s_d.byten = 1'b0;
            end
          end
          idw_pkg::ST_RDAT: begin
            // Master acks the read byte; we release the line
            s_d.ackph = 1'b1;
            s_d.sda_oe = 1'b0;
            // Second byte done marks the read complete
            s_d.rd_done = s_q.byten;
            s_d.byten = 1'b1;
          end
          default: begin
            s_d.st = idw_pkg::ST_SKIP;
          end
        endcase
      end else if (s_q.st == idw_pkg::ST_RDAT) begin
        // Drive next read bit, high byte first
        s_d.sda_oe = s_q.byten ? ~s_q.word[4'd7 - s_q.bitn[2:0]]
                               : ~s_q.word[4'd15 - {1'b0, s_q.bitn[2:0]}];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s_q <= '{scl_p: 1'b1, sda_p: 1'b1, st: idw_pkg::ST_IDLE, bitn: 4'h0, sh: 8'h00,
               byten: 1'b0, ackph: 1'b0, rd_done: 1'b0, word: idw_pkg::WORD_RST,
               pd: 1'b0, code: idw_pkg::CODE_RST, sda_oe: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe = s_q.sda_oe;
  assign soft_power_down_bit = s_q.pd;
  assign dac_code_bits = s_q.code;

  // ************************************************
  // Checks
  // ************************************************
  a_ack_drives_low: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
    (s_q.ackph && s_q.st == idw_pkg::ST_WDAT) |-> s_q.sda_oe)
    else $error("write ack not driven");
  a_dac_full_word: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
    $changed(s_q.code) |-> $past(s_q.st) == idw_pkg::ST_WDAT && $past(s_q.byten))
    else $error("dac updated without full word");
  a_read_clears: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
    (s_q.rd_done && (start_c || stop_c)) |=> s_q.word == 16'h0000)
    else $error("word not cleared after read");
  a_idle_line_free: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
    (s_q.st == idw_pkg::ST_IDLE) |-> !s_q.sda_oe)
    else $error("line pulled while idle");
  a_refused_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
    (s_q.st == idw_pkg::ST_SKIP) |-> !s_q.sda_oe)
    else $error("line pulled for foreign address");
  a_read_ack_free: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
    (s_q.ackph && s_q.st == idw_pkg::ST_RDAT && s_q.byten) |-> !s_q.sda_oe)
    else $error("line held during master ack");
  a_pd_full_word: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
    $changed(s_q.pd) |-> $past(s_q.st) == idw_pkg::ST_WDAT && $past(s_q.byten))
    else $error("power-down changed without full word");
endmodule

// ### idw_master.sv
module idw_master (
  input wire logic ref_clk,
  input wire logic sda_o,
  input wire logic sda_oe,
  output logic scl_i,
  output logic sda_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic md;
  // ***********************************
  // Open-drain bus, pull-up when idle
  // ***********************************
  assign sda_i = md & (~sda_oe | sda_o);
  initial begin
    md = 1'b1;
    scl_i = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Data moves mid-low so it never races the SCL edge
  task automatic slot(input logic b, output logic r);
    wt(5);
    md = b;
    wt(5);
    scl_i = 1'b1;
    wt(10);
    r = sda_i;
    scl_i = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] ab, input logic [15:0] w, input int n,
                      output logic [15:0] r, output logic [2:0] ak);
    logic b;
    ak = 3'h7;
    r = 16'h0000;
    wt(10);
    md = 1'b0;
    wt(10);
    scl_i = 1'b0;
    for (int i = 7; i >= 0; i--) slot(ab[i], b);
    slot(1'b1, ak[0]);
    for (int k = 0; k < n; k++) begin
      for (int j = 0; j < 8; j++) slot(ab[0] | w[15-8*k-j], r[15-8*k-j]);
      slot(ab[0] ? (k == n - 1) : 1'b1, ak[k+1]);
    end
    wt(5);
    md = 1'b0;
    wt(5);
    scl_i = 1'b1;
    wt(10);
    md = 1'b1;
    wt(20);
  endtask
endmodule

// ### i2c_dac_input_word_tb.sv
module i2c_dac_input_word_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, resetn, scl_i, sda_i, sda_o, sda_oe, pd;
  logic [9:0] code;
  logic [15:0] r;
  logic [2:0] ak;
  int failures, checked;
  idw_top dut (.ref_clk(ref_clk), .resetn(resetn), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .soft_power_down_bit(pd), .dac_code_bits(code));
  idw_master m (.ref_clk(ref_clk), .sda_o(sda_o), .sda_oe(sda_oe), .scl_i(scl_i),
    .sda_i(sda_i));
  // ***********************************
  // Checking and scenarios
  // ***********************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic t_write;
    m.xfer(8'h18, 16'h7FFF, 2, r, ak);
    chk({5'h00, pd, code}, 16'h03FF);
    m.xfer(8'h1E, 16'h8FF0, 2, r, ak);
    chk({13'h0000, ak}, 16'h0000);
    chk({15'h0000, sda_o}, 16'h0000);
    chk({5'h00, pd, code}, 16'h04FF);
    $display("write test done");
  endtask
  task automatic t_read;
    m.xfer(8'h1B, 16'h0000, 2, r, ak);
    chk({15'h0000, ak[0]}, 16'h0000);
    chk(r, 16'h8FF0);
    m.xfer(8'h1D, 16'h0000, 2, r, ak);
    chk(r, 16'h0000);
    $display("read test done");
  endtask
  task automatic t_refuse;
    m.xfer(8'h38, 16'h0000, 0, r, ak);
    chk({15'h0000, ak[0]}, 16'h0001);
    m.xfer(8'h18, 16'h1230, 1, r, ak);
    chk({5'h00, pd, code}, 16'h04FF);
    $display("refuse test done");
  endtask
  task automatic give_verdict;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    resetn = 1'b0;
    failures = 0;
    checked = 0;
    repeat (12) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (8) @(negedge ref_clk);
    t_write();
    t_read();
    t_refuse();
    give_verdict();
  end
endmodule
